// File: rtl/arp_port.sv
module arp_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic wr;
  logic rd;

  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;
  assign in_ready = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data = mem[rp_ff];

  always_ff @(posedge clock)
  begin
    if (wr)
      mem[wp_ff] <= in_data;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (wr)
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      if (rd)
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule : arp_fifo

module arp_port
  import arp_pkg::*;
#(
  parameter int BUF_DEPTH = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire arp_pins_t pins,
  input wire arp_res_t res_data,
  input wire logic res_valid,
  output logic res_ready,
  output logic [15:0] db_out,
  output logic db_oe,
  output logic result_valid_flag
);
  arp_pins_t sync1_ff;
  arp_pins_t sync2_ff;
  arp_cfg_t cfg_s;
  arp_cfg_t cfg_lat_ff;
  arp_res_t buf_out;
  arp_res_t q_ff [ARP_QD];
  arp_res_t nxt_q [ARP_QD];
  arp_res_t src;
  logic [15:0] chan_reg_ff [ARP_NCH];
  logic [ARP_NCH-1:0] chan_seen_ff;
  logic [4:0] q_cnt_ff;
  logic [4:0] nxt_q_cnt;
  logic [4:0] lat_tmr_ff;
  logic [2:0] cptr_ff;
  logic [1:0] phase_ff;
  logic [1:0] cur_phase;
  logic [15:0] db_out_ff;
  logic db_oe_ff;
  logic act;
  logic act_d_ff;
  logic trig_d_ff;
  logic rd_start;
  logic rd_end;
  logic trig_fall;
  logic mode_chg;
  logic buf_valid;
  logic buf_in_ready;
  logic store_fire;
  logic pop;
  logic last_ph;
  logic armed_ff;
  logic src_vld;

  function automatic logic [1:0] last_phase(input arp_cfg_t c);
    logic [1:0] n;
    n = c.byte_mode ? 2'h1 : 2'h0;
    if (c.addr_append && c.sel >= SEL_CYCLE)
      n = n + 2'h1;
    return n;
  endfunction : last_phase

  function automatic logic [15:0] fmt(input arp_cfg_t c, input logic [1:0] ph,
                                      input arp_res_t r, input logic v);
    logic [1:0] dp;
    dp = (c.addr_append && c.sel >= SEL_CYCLE) ? ph - 2'h1 : ph;
    if (c.addr_append && c.sel >= SEL_CYCLE && ph == PH_FIRST)
    begin
      if (c.byte_mode)
        return {2{v, r.chan, r.data[3:0]}};
      return {TAG_PREFIX, v, r.chan};
    end
    if (!c.byte_mode)
      return r.data;
    // either byte lane carries the same byte
    return (dp == 2'h0) ? {2{r.data[7:0]}} : {2{r.data[15:8]}};
  endfunction : fmt

  // pins come from outside; first stage feeds only the second
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_ff <= PINS_IDLE;
      sync2_ff <= PINS_IDLE;
      act_d_ff <= 1'b0;
      trig_d_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      act_d_ff <= act;
      trig_d_ff <= sync2_ff.sample_trigger_n;
    end
  end

  assign act = ~sync2_ff.cs_n & ~sync2_ff.rd_n;
  assign rd_start = act & ~act_d_ff;
  assign rd_end = ~act & act_d_ff;
  assign trig_fall = trig_d_ff & ~sync2_ff.sample_trigger_n;
  assign cfg_s = {sync2_ff.addr_append, sync2_ff.byte_mode, sync2_ff.mode_select_bit2,
                  sync2_ff.mode_select_bit1, sync2_ff.mode_select_bit0};
  // address append has no meaning in direct mode, so it does not count as a change
  assign mode_chg = rd_start && (cfg_s.sel != cfg_lat_ff.sel
                    || cfg_s.byte_mode != cfg_lat_ff.byte_mode
                    || (cfg_s.sel >= SEL_CYCLE && cfg_s.addr_append != cfg_lat_ff.addr_append));
  assign cur_phase = mode_chg ? PH_FIRST : phase_ff;
  assign last_ph = phase_ff == last_phase(cfg_lat_ff);
  assign pop = rd_end && last_ph && armed_ff && cfg_lat_ff.sel == SEL_FIFO && q_cnt_ff != '0;
  // results are held back during a read so the word on the pins never changes under it
  assign store_fire = buf_valid & ~act & (lat_tmr_ff == CNT_RST);

  always_comb
  begin
    if (cfg_s.sel == SEL_FIFO)
    begin
      src = q_ff[0];
      src_vld = q_cnt_ff != '0;
    end
    else
    begin
      src.chan = (cfg_s.sel == SEL_CYCLE) ? cptr_ff : cfg_s.sel;
      src.data = chan_reg_ff[src.chan];
      src_vld = chan_seen_ff[src.chan];
    end
  end

  arp_fifo #(
    .WIDTH($bits(arp_res_t)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_data(res_data),
    .in_valid(res_valid),
    .in_ready(buf_in_ready),
    .out_data(buf_out),
    .out_valid(buf_valid),
    .out_ready(store_fire)
  );

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      lat_tmr_ff <= CNT_RST;
    else if (trig_fall)
      lat_tmr_ff <= LAT_CYC;
    else if (lat_tmr_ff != CNT_RST)
      lat_tmr_ff <= lat_tmr_ff - 5'h01;
  end

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q_cnt = q_cnt_ff;
    if (pop)
    begin
      for (int i = 0; i < ARP_QD - 1; i++)
        nxt_q[i] = nxt_q[i+1];
      nxt_q_cnt = nxt_q_cnt - 5'h01;
    end
    if (store_fire)
    begin
      if (nxt_q_cnt == 5'(ARP_QD))
      begin
        for (int i = 0; i < ARP_QD - 1; i++)
          nxt_q[i] = nxt_q[i+1];
        nxt_q[ARP_QD-1] = buf_out;
      end
      else
      begin
        nxt_q[nxt_q_cnt] = buf_out;
        nxt_q_cnt = nxt_q_cnt + 5'h01;
      end
    end
  end

  // queue holds three slots per channel, shared in arrival order
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q_cnt_ff <= CNT_RST;
      for (int i = 0; i < ARP_QD; i++)
        q_ff[i] <= '0;
    end
    else
    begin
      q_cnt_ff <= nxt_q_cnt;
      q_ff <= nxt_q;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      chan_seen_ff <= '0;
      for (int i = 0; i < ARP_NCH; i++)
        chan_reg_ff[i] <= DOUT_RST;
    end
    else if (store_fire && buf_out.chan <= SEL_LAST_CH)
    begin
      chan_reg_ff[buf_out.chan] <= buf_out.data;
      chan_seen_ff[buf_out.chan] <= 1'b1;
    end
  end

  // read sequencing; the host keeps select steady while strobed
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_lat_ff <= CFG_RST;
      phase_ff <= PH_FIRST;
      cptr_ff <= 3'h0;
      armed_ff <= 1'b0;
    end
    else if (rd_start)
    begin
      cfg_lat_ff <= cfg_s;
      phase_ff <= cur_phase;
    end
    else if (rd_end)
    begin
      // first fifo read after reset only sets up the tag state
      if (cfg_lat_ff.sel == SEL_FIFO && !armed_ff)
        armed_ff <= 1'b1;
      else if (!last_ph)
        phase_ff <= phase_ff + 2'h1;
      else
      begin
        phase_ff <= PH_FIRST;
        if (cfg_lat_ff.sel == SEL_CYCLE)
          cptr_ff <= (cptr_ff == SEL_LAST_CH) ? 3'h0 : cptr_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      db_out_ff <= DOUT_RST;
      db_oe_ff <= 1'b0;
      res_ready <= 1'b0;
      result_valid_flag <= 1'b0;
    end
    else
    begin
      db_oe_ff <= act;
      res_ready <= buf_in_ready;
      result_valid_flag <= nxt_q_cnt != '0;
      if (rd_start)
      begin
        if (cfg_s.sel == SEL_FIFO && q_cnt_ff == '0)
          db_out_ff <= DOUT_RST;
        else
          db_out_ff <= fmt(cfg_s, cur_phase, src, src_vld);
      end
    end
  end

  assign db_out = db_out_ff;
  assign db_oe = db_oe_ff;

  AST_OE_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
    !act |=> !db_oe_ff) else $error("data driven outside read");
  AST_SEL_LATCH: assert property (@(posedge clock) disable iff (sys_rst)
    rd_start |=> cfg_lat_ff == $past(cfg_s)) else $error("select not latched");
  AST_DIRECT_WORD: assert property (@(posedge clock) disable iff (sys_rst)
    rd_start && cfg_s.sel <= SEL_LAST_CH && !cfg_s.byte_mode
    |=> db_out_ff == chan_reg_ff[cfg_lat_ff.sel]) else $error("direct word wrong");
  AST_EMPTY_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
    rd_start && cfg_s.sel == SEL_FIFO && q_cnt_ff == '0 |=> db_out_ff == DOUT_RST)
    else $error("empty read not zero");
  AST_DEFER: assert property (@(posedge clock) disable iff (sys_rst)
    act |-> !store_fire) else $error("store during read");
  AST_WRAP: assert property (@(posedge clock) disable iff (sys_rst)
    rd_end && cfg_lat_ff.sel == SEL_CYCLE && last_ph && cptr_ff == SEL_LAST_CH
    |=> cptr_ff == 3'h0) else $error("cycle did not wrap");
  AST_DROP: assert property (@(posedge clock) disable iff (sys_rst)
    store_fire && !pop && q_cnt_ff == 5'(ARP_QD) |=> q_cnt_ff == 5'(ARP_QD))
    else $error("full queue count moved");
  AST_PUSH: assert property (@(posedge clock) disable iff (sys_rst)
    store_fire && !pop && q_cnt_ff < 5'(ARP_QD)
    |=> q_cnt_ff == $past(q_cnt_ff) + 5'h01 && q_ff[$past(q_cnt_ff)] == $past(buf_out))
    else $error("push slot wrong");
  AST_POP: assert property (@(posedge clock) disable iff (sys_rst)
    pop && !store_fire && q_cnt_ff > 5'h01 |=> q_ff[0] == $past(q_ff[1]))
    else $error("pop did not shift");
  AST_TAG_WORD: assert property (@(posedge clock) disable iff (sys_rst)
    rd_start && cfg_s.sel == SEL_FIFO && cfg_s.addr_append && !cfg_s.byte_mode
    && cur_phase == PH_FIRST && q_cnt_ff != '0
    |=> db_out_ff == {TAG_PREFIX, 1'b1, q_ff[0].chan}) else $error("tag word wrong");
  AST_LATENCY: assert property (@(posedge clock) disable iff (sys_rst)
    trig_fall |=> !store_fire [*8]) else $error("result stored too early");
  AST_PHASE_RST: assert property (@(posedge clock) disable iff (sys_rst)
    mode_chg |=> phase_ff == PH_FIRST) else $error("phase kept on mode change");

  CV_CYCLE_WRAP: cover property (@(posedge clock) disable iff (sys_rst)
    rd_end && cfg_lat_ff.sel == SEL_CYCLE && cptr_ff == SEL_LAST_CH && last_ph);
  CV_FIFO_FULL_DROP: cover property (@(posedge clock) disable iff (sys_rst)
    store_fire && q_cnt_ff == 5'(ARP_QD));
  CV_BYTE_TAG: cover property (@(posedge clock) disable iff (sys_rst)
    rd_end && cfg_lat_ff.byte_mode && cfg_lat_ff.addr_append && phase_ff == 2'h2);
  CV_BUF_FULL: cover property (@(posedge clock) disable iff (sys_rst) !buf_in_ready);
endmodule : arp_port

// File: rtl/arp_pkg.sv
package arp_pkg;
  localparam int ARP_NCH = 6;
  localparam int ARP_SLOTS = 3;
  localparam int ARP_QD = ARP_NCH * ARP_SLOTS;
  localparam logic [2:0] SEL_LAST_CH = 3'h5;
  localparam logic [2:0] SEL_CYCLE = 3'h6;
  localparam logic [2:0] SEL_FIFO = 3'h7;
  localparam logic [11:0] TAG_PREFIX = 12'h800;
  localparam logic [1:0] PH_FIRST = 2'h0;
  // latency is printed as 16.5 sample clocks; counted in half cycles, rounded up
  localparam int LAT_HALF_CYC = 33;
  localparam logic [4:0] LAT_CYC = 5'((LAT_HALF_CYC + 1) / 2);
  localparam logic [15:0] DOUT_RST = 16'h0000;
  localparam logic [4:0] CNT_RST = 5'h00;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic sample_trigger_n;
    logic addr_append;
    logic byte_mode;
    logic mode_select_bit2;
    logic mode_select_bit1;
    logic mode_select_bit0;
  } arp_pins_t;

  typedef struct packed {
    logic addr_append;
    logic byte_mode;
    logic [2:0] sel;
  } arp_cfg_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [15:0] data;
  } arp_res_t;

  localparam arp_pins_t PINS_IDLE = 8'hE0;
  localparam arp_cfg_t CFG_RST = 5'h00;
endpackage : arp_pkg

// File: tb/arp_host_model.sv
module arp_host_model
  import arp_pkg::*;
(
  input wire logic clock,
  output arp_pins_t pins,
  input wire logic [15:0] db_out,
  input wire logic db_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial pins = PINS_IDLE;

  // one read strobe; hold stretches the low time so the device sees a stalled host
  task automatic rd(input logic [2:0] sel, input logic bm, input logic app, input int hold,
                    output logic [15:0] d);
    @(posedge clock);
    #2;
    {pins.mode_select_bit2, pins.mode_select_bit1, pins.mode_select_bit0} = sel;
    pins.byte_mode = bm;
    pins.addr_append = app;
    @(posedge clock);
    #2;
    // select stays put for the whole low time
    pins.cs_n = 1'b0;
    pins.rd_n = 1'b0;
    repeat (5) @(posedge clock);
    #2;
    // an undriven bus must never pass for data
    d = (db_oe === 1'b1) ? db_out : 16'hXXXX;
    repeat (hold) @(posedge clock);
    #2;
    pins.cs_n = 1'b1;
    pins.rd_n = 1'b1;
    repeat (6) @(posedge clock);
    #2;
  endtask : rd

  task automatic trig();
    pins.sample_trigger_n = 1'b0;
    repeat (3) @(posedge clock);
    #2;
    pins.sample_trigger_n = 1'b1;
  endtask : trig
endmodule : arp_host_model

// File: tb/tb_top.sv
module tb_top
  import arp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock;
  logic sys_rst;
  logic res_valid;
  logic res_ready;
  logic db_oe;
  logic result_valid_flag;
  logic [15:0] db_out;
  logic [15:0] d;
  arp_pins_t pins;
  arp_res_t res_data;
  int n_mismatch;
  int cmp_count;
  int cyc;

  arp_port #(.BUF_DEPTH(32)) uut (.clock(clock), .sys_rst(sys_rst), .pins(pins),
    .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready), .db_out(db_out),
    .db_oe(db_oe), .result_valid_flag(result_valid_flag));

  arp_host_model host (.clock(clock), .pins(pins), .db_out(db_out), .db_oe(db_oe));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [15:0] d_of(input int i);
    return 16'h3C00 + 16'h1111 * i[15:0];
  endfunction : d_of

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: data %h, want %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask : chk1

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic rdx(input logic [2:0] sel, input logic bm, input logic app,
                     input logic [15:0] exp);
    host.rd(sel, bm, app, 0, d);
    chk16(d, exp);
  endtask : rdx

  // valid stays up between words, so back-to-back offers never re-assign it in one step
  task automatic push(input logic [2:0] ch, input logic [15:0] v);
    int n;
    n = 0;
    while (res_ready !== 1'b1 && n < 200)
    begin
      @(posedge clock);
      #2;
      n++;
    end
    res_data = {ch, v};
    res_valid = 1'b1;
    @(posedge clock);
    #2;
  endtask : push

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (12) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    @(posedge clock);
    #2;
    chk1(res_ready, 1'b1);
    chk1(db_oe, 1'b0);
    chk1(result_valid_flag, 1'b0);
    $display("reset test done");
  endtask : do_reset

  task automatic t_direct();
    logic [15:0] e;
    host.trig();
    for (int c = 0; c < 6; c++) push(3'(c), d_of(c));
    res_valid = 1'b0;
    // timer loads at clock 3, first store LAT_CYC later, flag one clock after that
    repeat (LAT_CYC - 6) @(posedge clock);
    #2;
    chk1(result_valid_flag, 1'b0);
    @(posedge clock);
    #2;
    chk1(result_valid_flag, 1'b1);
    repeat (18) @(posedge clock);
    #2;
    for (int c = 0; c < 6; c++) rdx(3'(c), 1'b0, c[0], d_of(c));
    e = d_of(4);
    rdx(3'h4, 1'b1, 1'b0, {2{e[7:0]}});
    rdx(3'h4, 1'b1, 1'b0, {2{e[15:8]}});
    $display("direct test done");
  endtask : t_direct

  task automatic t_cycle();
    logic [15:0] e;
    for (int k = 0; k < 7; k++) rdx(SEL_CYCLE, 1'b0, 1'b0, d_of(k % 6));
    e = d_of(1);
    rdx(SEL_CYCLE, 1'b1, 1'b0, {2{e[7:0]}});
    rdx(SEL_CYCLE, 1'b1, 1'b0, {2{e[15:8]}});
    e = d_of(2);
    rdx(SEL_CYCLE, 1'b1, 1'b0, {2{e[7:0]}});
    rdx(SEL_CYCLE, 1'b0, 1'b1, {TAG_PREFIX, 1'b1, 3'h2});
    rdx(SEL_CYCLE, 1'b0, 1'b1, e);
    $display("cycle test done");
  endtask : t_cycle

  task automatic t_fifo();
    logic [15:0] e;
    do_reset();
    host.rd(SEL_FIFO, 1'b0, 1'b0, 0, d); // dummy read to align the tag bits
    host.trig();
    fork
      host.rd(SEL_FIFO, 1'b0, 1'b0, 100, d);
      begin
        repeat (4) @(posedge clock);
        #2;
        for (int i = 0; i < 32; i++) push(3'(i % 6), 16'h0A00 + 16'(i));
        res_valid = 1'b0;
        repeat (3) @(posedge clock);
        #2;
        chk1(res_ready, 1'b0);
        chk1(result_valid_flag, 1'b0);
      end
    join
    repeat (60) @(posedge clock);
    #2;
    chk1(res_ready, 1'b1);
    chk1(result_valid_flag, 1'b1);
    // 32 offered, 18 kept: the oldest 14 are gone
    e = 16'h0A00 + 16'h000E;
    rdx(SEL_FIFO, 1'b1, 1'b1, {2{1'b1, 3'h2, e[3:0]}});
    rdx(SEL_FIFO, 1'b1, 1'b1, {2{e[7:0]}});
    rdx(SEL_FIFO, 1'b1, 1'b1, {2{e[15:8]}});
    // tag phase only; the next read changes mode, so it restarts on the data of word 15
    rdx(SEL_FIFO, 1'b0, 1'b1, {TAG_PREFIX, 1'b1, 3'h3});
    for (int i = 15; i < 32; i++) rdx(SEL_FIFO, 1'b0, 1'b0, 16'h0A00 + 16'(i));
    chk1(result_valid_flag, 1'b0);
    rdx(SEL_FIFO, 1'b0, 1'b1, 16'h0000);
    $display("fifo test done");
  endtask : t_fifo

  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    sys_rst = 1'b1;
    res_valid = 1'b0;
    res_data = '0;
    do_reset();
    t_direct();
    t_cycle();
    t_fifo();
    final_report();
  end
endmodule : tb_top
